// *** logic/vic_controller.sv ***
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "vic_regs.svh"

module vic_controller
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire vic_pkg::vic_regreq_t regReq,
    output logic [15:0]               regRdData,
    input  wire logic [15:1]          srcRequest,
    input  wire logic [2:0]           extLine_n,
    input  wire vic_pkg::vic_iack_t   iack,
    output vic_pkg::vic_answer_t      answer,
    output logic [2:0]                priorityLevel,
    output logic                      internalRequest
);

    logic [15:0] modeReg_q;
    logic        baseWritten_q;
    logic [15:0] pending_q;
    logic [15:0] pending_d;
    logic [15:0] mask_q;
    logic [15:0] inService_q;
    logic [15:0] inService_d;
    logic [15:0] rdData_q;
    logic [2:0]  extSync1_q;
    logic [2:0]  extSync2_q;
    logic [2:0]  extPrev_q;
    logic [2:0]  edgeLatch_q;
    logic [2:0]  edgeLatch_d;
    logic [2:0]  extReq;
    logic [2:0]  extEncLevel;
    logic        dedicated;
    logic [2:0]  edgeSel;
    logic [2:0]  vecSrc;
    logic [3:0]  candIdx;
    logic        candValid;
    logic [3:0]  topInService;
    logic        intReq;
    logic [2:0]  level_d;
    logic [2:0]  level_q;
    logic        intReq_q;
    logic        ansValid_d;
    logic [4:0]  ansCode;
    logic [7:0]  vector_d;
    logic        ansValid_q;
    logic [7:0]  vector_q;
    logic [15:0] ackClear;
    logic        errSet;
    logic [2:0]  lineAcked;
    logic        wrMode;
    logic        wrPending;
    logic        wrMask;
    logic        wrInService;

    // index of highest set bit above bit 0, zero when none
    function automatic logic [3:0] vic_top_bit(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 1; i < 16; i++)
        begin
            if (v[i])
            begin
                r = 4'(i);
            end
        end
        return r;
    endfunction : vic_top_bit

    assign wrMode      = regReq.wr && (regReq.addr == `VIC_OFS_MODE);
    assign wrPending   = regReq.wr && (regReq.addr == `VIC_OFS_PENDING);
    assign wrMask      = regReq.wr && (regReq.addr == `VIC_OFS_MASK);
    assign wrInService = regReq.wr && (regReq.addr == `VIC_OFS_IN_SERVICE);

    assign dedicated = modeReg_q[`VIC_MODE_SEL_BIT];
    assign edgeSel   = {modeReg_q[`VIC_EDGE7_BIT],
                        modeReg_q[`VIC_EDGE6_BIT],
                        modeReg_q[`VIC_EDGE1_BIT]};
    assign vecSrc    = {modeReg_q[`VIC_VSRC7_BIT],
                        modeReg_q[`VIC_VSRC6_BIT],
                        modeReg_q[`VIC_VSRC1_BIT]};

    // mode register, reserved bits never stored; also remembers any base write
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            modeReg_q     <= `VIC_MODE_RST;
            baseWritten_q <= 1'b0;
        end
        else if (wrMode)
        begin
            modeReg_q     <= regReq.wrData & `VIC_MODE_WR_MASK;
            baseWritten_q <= 1'b1;
        end
    end

    // external lines come from pins: two stage synchroniser
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            extSync1_q  <= 3'h7;
            extSync2_q  <= 3'h7;
            extPrev_q   <= 3'h7;
            edgeLatch_q <= 3'h0;
        end
        else
        begin
            extSync1_q  <= extLine_n;
            extSync2_q  <= extSync1_q;
            extPrev_q   <= extSync2_q;
            edgeLatch_q <= edgeLatch_d;
        end
    end

    // falling edges held until the matching acknowledge
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            edgeLatch_d[i] = edgeLatch_q[i];
            if (lineAcked[i])
            begin
                edgeLatch_d[i] = 1'b0;
            end
            if (extPrev_q[i] && !extSync2_q[i])
            begin
                edgeLatch_d[i] = 1'b1;
            end
        end
    end

    // dedicated line requests: index 2 level 7, 1 level 6, 0 level 1
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (edgeSel[i])
            begin
                extReq[i] = edgeLatch_q[i];
            end
            else
            begin
                extReq[i] = !extSync2_q[i];
            end
        end
    end

    // normal mode: lines carry an active-low encoded level
    assign extEncLevel = ~extSync2_q;

    // internal request selection
    always_comb
    begin
        candIdx      = vic_top_bit(pending_q & mask_q);
        topInService = vic_top_bit(inService_q);
        candValid    = (candIdx != 4'h0) && (candIdx > topInService);
        intReq       = candValid;
    end

    // level presented to the core
    always_comb
    begin
        level_d = `VIC_LEVEL_NONE;
        if (dedicated)
        begin
            if (extReq[2])
            begin
                level_d = `VIC_LEVEL_7;
            end
            else if (extReq[1])
            begin
                level_d = `VIC_LEVEL_6;
            end
            else if (intReq)
            begin
                level_d = `VIC_LEVEL_4;
            end
            else if (extReq[0])
            begin
                level_d = `VIC_LEVEL_1;
            end
        end
        else
        begin
            level_d = extEncLevel;
            if (intReq && (extEncLevel < `VIC_LEVEL_4))
            begin
                level_d = `VIC_LEVEL_4;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_q    <= `VIC_LEVEL_NONE;
            intReq_q   <= 1'b0;
            ansValid_q <= 1'b0;
            vector_q   <= 8'h00;
        end
        else
        begin
            level_q    <= level_d;
            intReq_q   <= intReq;
            ansValid_q <= ansValid_d;
            vector_q   <= ansValid_d ? vector_d : 8'h00;
        end
    end

    // acknowledge decode
    always_comb
    begin
        ansValid_d = 1'b0;
        ansCode    = `VIC_CODE_ERROR;
        ackClear   = 16'h0000;
        errSet     = 1'b0;
        lineAcked  = 3'h0;
        if (iack.valid)
        begin
            case (iack.level)
                `VIC_LEVEL_4:
                begin
                    ansValid_d = 1'b1;
                    if (candValid)
                    begin
                        ansCode           = {1'b0, candIdx};
                        ackClear[candIdx] = 1'b1;
                    end
                    else
                    begin
                        ansCode = `VIC_CODE_ERROR;
                        errSet  = 1'b1;
                    end
                end
                `VIC_LEVEL_7:
                begin
                    lineAcked[2] = 1'b1;
                    ansCode      = `VIC_CODE_LVL7;
                    ansValid_d   = !vecSrc[2] &&
                                   !(dedicated && !edgeSel[2] && extSync2_q[2]);
                end
                `VIC_LEVEL_6:
                begin
                    lineAcked[1] = 1'b1;
                    ansCode      = `VIC_CODE_LVL6;
                    ansValid_d   = !vecSrc[1] &&
                                   !(dedicated && !edgeSel[1] && extSync2_q[1]);
                end
                `VIC_LEVEL_1:
                begin
                    lineAcked[0] = 1'b1;
                    ansCode      = `VIC_CODE_LVL1;
                    ansValid_d   = !vecSrc[0] &&
                                   !(dedicated && !edgeSel[0] && extSync2_q[0]);
                end
                default:
                begin
                    ansValid_d = 1'b0;
                end
            endcase
        end
    end

    // base above code, or the fixed vector until the base is programmed
    always_comb
    begin
        if (baseWritten_q)
        begin
            vector_d = {modeReg_q[`VIC_BASE_MSB:`VIC_BASE_LSB], ansCode};
        end
        else
        begin
            vector_d = `VIC_VECTOR_UNSET;
        end
    end

    // pending: a new request wins over any clear in the same cycle
    always_comb
    begin
        pending_d = pending_q & ~ackClear;
        if (wrPending)
        begin
            pending_d = pending_d & ~regReq.wrData;
        end
        pending_d = pending_d | {srcRequest, errSet};
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_q <= `VIC_PENDING_RST;
        end
        else
        begin
            pending_q <= pending_d;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mask_q <= `VIC_MASK_RST;
        end
        else if (wrMask)
        begin
            mask_q <= {regReq.wrData[15:1], 1'b0};
        end
    end

    // in-service: delivery sets, write of one clears, set wins
    always_comb
    begin
        inService_d = inService_q;
        if (wrInService)
        begin
            inService_d = inService_d & ~regReq.wrData;
        end
        inService_d = (inService_d | ackClear) & 16'hfffe;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            inService_q <= `VIC_IN_SERVICE_RST;
        end
        else
        begin
            inService_q <= inService_d;
        end
    end

    // read data stands in the cycle after the read strobe only
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdData_q <= 16'h0000;
        end
        else if (regReq.rd)
        begin
            case (regReq.addr)
                `VIC_OFS_MODE:       rdData_q <= modeReg_q;
                `VIC_OFS_PENDING:    rdData_q <= pending_q;
                `VIC_OFS_MASK:       rdData_q <= mask_q;
                `VIC_OFS_IN_SERVICE: rdData_q <= inService_q;
                default:             rdData_q <= 16'h0000;
            endcase
        end
        else
        begin
            rdData_q <= 16'h0000;
        end
    end

    assign regRdData          = rdData_q;
    assign answer.transferAck = ansValid_q;
    assign answer.vector      = vector_q;
    assign priorityLevel      = level_q;
    assign internalRequest    = intReq_q;

endmodule : vic_controller

// *** logic/vic_pkg.sv ***
package vic_pkg;

    // acknowledge cycle started by the core
    typedef struct packed {
        logic       valid;
        logic [2:0] level;
    } vic_iack_t;

    // answer returned to the core
    typedef struct packed {
        logic       transferAck;
        logic [7:0] vector;
    } vic_answer_t;

    // register port request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wrData;
    } vic_regreq_t;

endpackage : vic_pkg

// *** logic/vic_regs.svh ***
`ifndef VIC_REGS_SVH
`define VIC_REGS_SVH

// register offsets on the plain register port
`define VIC_OFS_MODE        8'h00
`define VIC_OFS_PENDING     8'h02
`define VIC_OFS_MASK        8'h04
`define VIC_OFS_IN_SERVICE  8'h06

// global interrupt mode fields
`define VIC_MODE_SEL_BIT    15
`define VIC_VSRC7_BIT       14
`define VIC_VSRC6_BIT       13
`define VIC_VSRC1_BIT       12
`define VIC_EDGE7_BIT       10
`define VIC_EDGE6_BIT       9
`define VIC_EDGE1_BIT       8
`define VIC_BASE_MSB        7
`define VIC_BASE_LSB        5
`define VIC_MODE_WR_MASK    16'hf7e0

// pending register error flag position
`define VIC_ERR_BIT         0

// reset values
`define VIC_MODE_RST        16'h0000
`define VIC_PENDING_RST     16'h0000
`define VIC_MASK_RST        16'h0000
`define VIC_IN_SERVICE_RST  16'h0000

// vector values
`define VIC_VECTOR_UNSET    8'h0f
`define VIC_CODE_ERROR      5'h00
`define VIC_CODE_LVL7       5'h17
`define VIC_CODE_LVL6       5'h16
`define VIC_CODE_LVL1       5'h11

// priority levels seen by the core
`define VIC_LEVEL_NONE      3'h0
`define VIC_LEVEL_1         3'h1
`define VIC_LEVEL_4         3'h4
`define VIC_LEVEL_6         3'h6
`define VIC_LEVEL_7         3'h7

`endif

// *** tb/tb_vectored_interrupt_controller.sv ***
`timescale 1ns/1ps
module tb_vectored_interrupt_controller;
    logic                 clock;
    logic                 rst_n;
    vic_pkg::vic_regreq_t req;
    logic [15:0]          rdData;
    logic [15:1]          src;
    logic [2:0]           extN;
    vic_pkg::vic_iack_t   iack;
    vic_pkg::vic_answer_t answer;
    logic [2:0]           level;
    logic                 intReq;
    logic                 go;
    logic [2:0]           goLevel;
    logic                 gotAck;
    logic [7:0]           gotVec;
    int                   n_errors = 0;
    int                   n_tests = 0;

    vic_controller uut (.clock(clock), .rst_n(rst_n), .regReq(req), .regRdData(rdData),
        .srcRequest(src), .extLine_n(extN), .iack(iack), .answer(answer),
        .priorityLevel(level), .internalRequest(intReq));
    vic_core_model core (.clock(clock), .rst_n(rst_n), .go(go), .goLevel(goLevel),
        .iack(iack), .answer(answer), .gotAck(gotAck), .gotVec(gotVec));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_errors++;
            $display("BAD %0t: saw %h expected %h", $time, seen, want);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wrData <= d;
        @(posedge clock);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] want);
        @(posedge clock);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clock);
        req.rd <= 1'b0;
        #1 chk(rdData, want);
    endtask : rd

    // core acknowledge at a level; the vector is judged only when an answer is due
    task automatic ack(input logic [2:0] l, input logic wantAck, input logic [7:0] wantVec);
        @(posedge clock);
        go <= 1'b1;
        goLevel <= l;
        @(posedge clock);
        go <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk(16'(gotAck), 16'(wantAck));
        if (wantAck)
            chk(16'(gotVec), 16'(wantVec));
    endtask : ack

    task automatic pulse(input int i);
        @(posedge clock);
        src[i] <= 1'b1;
        @(posedge clock);
        src <= '0;
    endtask : pulse

    // pins pass two sync stages and a registered level
    task automatic line(input logic [2:0] v);
        @(posedge clock);
        extN <= v;
        repeat (4) @(posedge clock);
        #1;
    endtask : line

    task automatic t_reset_state;
        rd(8'h04, 16'h0000);
        rd(8'h02, 16'h0000);
        rd(8'h06, 16'h0000);
        rd(8'h08, 16'h0000);
        ack(3'h4, 1'b1, 8'h0f);
        rd(8'h02, 16'h0001);
        wr(8'h02, 16'h0001);
        rd(8'h02, 16'h0000);
        $display("done reset_state");
    endtask : t_reset_state

    task automatic t_mask;
        wr(8'h00, 16'h08bf);
        rd(8'h00, 16'h00a0);
        pulse(3);
        rd(8'h02, 16'h0008);
        chk(16'(intReq), 16'h0);
        wr(8'h04, 16'h0008);
        line(3'h7);
        chk(16'(intReq), 16'h1);
        chk(16'(level), 16'h4);
        wr(8'h04, 16'h0000);
        line(3'h7);
        chk(16'(intReq), 16'h0);
        rd(8'h02, 16'h0008);
        wr(8'h04, 16'h0008);
        line(3'h7);
        chk(16'(intReq), 16'h1);
        wr(8'h02, 16'h0000);
        rd(8'h02, 16'h0008);
        wr(8'h02, 16'h0008);
        rd(8'h02, 16'h0000);
        $display("done mask");
    endtask : t_mask

    task automatic t_nest;
        wr(8'h04, 16'h0228);
        pulse(3);
        pulse(5);
        line(3'h7);
        ack(3'h4, 1'b1, 8'ha5);
        rd(8'h02, 16'h0008);
        rd(8'h06, 16'h0020);
        chk(16'(intReq), 16'h0);
        pulse(9);
        line(3'h7);
        chk(16'(intReq), 16'h1);
        ack(3'h4, 1'b1, 8'ha9);
        wr(8'h06, 16'h0000);
        rd(8'h06, 16'h0220);
        wr(8'h06, 16'h0220);
        line(3'h7);
        ack(3'h4, 1'b1, 8'ha3);
        wr(8'h06, 16'h0008);
        ack(3'h4, 1'b1, 8'ha0);
        rd(8'h02, 16'h0001);
        wr(8'h02, 16'h0001);
        $display("done nest");
    endtask : t_nest

    task automatic t_ext;
        logic [2:0] lv [3] = '{3'h7, 3'h6, 3'h1};
        logic [4:0] cd [3] = '{5'h17, 5'h16, 5'h11};
        for (int k = 0; k < 3; k++)
        begin
            line(~lv[k]);
            chk(16'(level), 16'(lv[k]));
            ack(lv[k], 1'b1, {3'h5, cd[k]});
        end
        line(3'h7);
        ack(3'h3, 1'b0, 8'h00);
        wr(8'h00, 16'h40a0);
        line(3'h0);
        ack(3'h7, 1'b0, 8'h00);
        wr(8'h00, 16'h02a0);
        line(3'h1);
        ack(3'h6, 1'b1, 8'hb6);
        line(3'h1);
        chk(16'(level), 16'h6);
        wr(8'h00, 16'h80a0);
        line(3'h7);
        ack(3'h7, 1'b0, 8'h00);
        line(3'h3);
        chk(16'(level), 16'h7);
        ack(3'h7, 1'b1, 8'hb7);
        wr(8'h00, 16'h82a0);
        line(3'h5);
        chk(16'(level), 16'h6);
        ack(3'h6, 1'b1, 8'hb6);
        line(3'h5);
        chk(16'(level), 16'h0);
        line(3'h7);
        line(3'h5);
        chk(16'(level), 16'h6);
        line(3'h7);
        $display("done ext");
    endtask : t_ext

    initial
    begin
        repeat (30000) @(posedge clock);
        n_errors++;
        $display("BAD %0t: run did not finish", $time);
        close_out;
    end

    initial
    begin
        rst_n = 1'b0;
        req = '0;
        src = '0;
        extN = 3'h7;
        go = 1'b0;
        goLevel = 3'h0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_state;
        t_mask;
        t_nest;
        t_ext;
        close_out;
    end
endmodule : tb_vectored_interrupt_controller

// *** tb/vic_controller_props.sv ***
`timescale 1ns/1ps
module vic_controller_props
(
    input wire logic                 clock,
    input wire logic                 rst_n,
    input wire vic_pkg::vic_regreq_t regReq,
    input wire logic [15:0]          regRdData,
    input wire logic [15:1]          srcRequest,
    input wire logic [2:0]           extLine_n,
    input wire vic_pkg::vic_iack_t   iack,
    input wire vic_pkg::vic_answer_t answer,
    input wire logic [2:0]           priorityLevel,
    input wire logic                 internalRequest
);
    logic       baseSet_q;
    logic [2:0] base_q;
    logic       extVec7_q;

    // shadow of the programmed mode fields
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            baseSet_q <= 1'b0;
            base_q    <= 3'h0;
            extVec7_q <= 1'b0;
        end
        else if (regReq.wr && regReq.addr == 8'h00)
        begin
            baseSet_q <= 1'b1;
            base_q    <= regReq.wrData[7:5];
            extVec7_q <= regReq.wrData[14];
        end
    end

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_ack_has_cause: assert property (answer.transferAck |-> $past(iack.valid))
        else $error("vector answer without acknowledge");
    a_unset_vector: assert property (
        answer.transferAck && !baseSet_q |-> answer.vector == 8'h0f)
        else $error("vector not 0f before base written");
    a_base_bits: assert property (
        answer.transferAck && baseSet_q |-> answer.vector[7:5] == base_q)
        else $error("vector upper bits differ from base");
    a_lvl7_code: assert property (
        answer.transferAck && baseSet_q && $past(iack.level) == 3'h7
        |-> answer.vector[4:0] == 5'h17)
        else $error("wrong level 7 code");
    a_lvl4_code: assert property (
        answer.transferAck && baseSet_q && $past(iack.level) == 3'h4 |-> !answer.vector[4])
        else $error("level 4 code outside internal range");
    a_bad_level: assert property (
        iack.valid && (iack.level inside {3'h0, 3'h2, 3'h3, 3'h5}) |=> !answer.transferAck)
        else $error("answer for a level without vector");
    a_ext_vec7: assert property (
        iack.valid && iack.level == 3'h7 && extVec7_q |=> !answer.transferAck)
        else $error("answer although external vector chosen");
    a_req_level: assert property (internalRequest |-> priorityLevel >= 3'h4)
        else $error("internal request without level 4");
    a_rd_window: assert property (regRdData != 16'h0000 |-> $past(regReq.rd))
        else $error("read data outside read window");
endmodule : vic_controller_props

bind vic_controller vic_controller_props u_props
(
    .clock           (clock),
    .rst_n           (rst_n),
    .regReq          (regReq),
    .regRdData       (regRdData),
    .srcRequest      (srcRequest),
    .extLine_n       (extLine_n),
    .iack            (iack),
    .answer          (answer),
    .priorityLevel   (priorityLevel),
    .internalRequest (internalRequest)
);

// *** tb/vic_core_model.sv ***
`timescale 1ns/1ps
module vic_core_model
(
    input  wire logic                 clock,
    input  wire logic                 rst_n,
    input  wire logic                 go,
    input  wire logic [2:0]           goLevel,
    output vic_pkg::vic_iack_t        iack,
    input  wire vic_pkg::vic_answer_t answer,
    output logic                      gotAck,
    output logic [7:0]                gotVec
);
    logic waiting_q;

    // one-cycle acknowledge; idle level keeps changing so it is never trusted
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            iack      <= '0;
            waiting_q <= 1'b0;
        end
        else
        begin
            iack.valid <= go;
            iack.level <= go ? goLevel : ~iack.level;
            waiting_q  <= iack.valid;
        end
    end

    // the answer stands one cycle only, so it is captured right then
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gotAck <= 1'b0;
            gotVec <= 8'h00;
        end
        else if (waiting_q)
        begin
            gotAck <= answer.transferAck;
            gotVec <= answer.vector;
        end
    end
endmodule : vic_core_model
